/* cpu_reset_control.sv */
// What this block does
// - hardware reset sets host interrupt output bit 12 of status register 3 to one
// - hardware reset clears cache flush control bit 13; software sets and polls it
// - hardware reset clears cache enable bit 14, program cache disabled
// - hardware reset clears cache freeze bit 15, cache not frozen
// - hardware reset clears temporary register 2 with the shift field under legacy mode
// - reset aborts work, flushes the pipeline and loads register reset values
// - after reset actions the core runs the reset routine like a nonmaskable interrupt
// - bits 29 and 28 of the reset vector word choose the stack configuration
// - a reset pulse asserted and released during emulation halt is ignored
// - after hardware reset all interrupts blocked until both stack pointers written
// - then global mask and both enable registers govern maskable interrupt acceptance
// - the software reset instruction runs the reset vector flow too
// - software reset changes only flag registers and status registers 0 to 2
// - software reset loads the same values as hardware reset
// - reset sets legacy compatibility mode bit 5 of status register 1
// - reset sets global interrupt mask bit 11 of status register 1
// - reset clears shift field bits 0 to 4 of status register 1
module cpu_reset_control
    import crc_pkg::*;
(
    input  wire logic                    clock,          // Core clock
    input  wire logic                    rst_b,          // Async power-on reset
    input  wire logic                    hw_reset_b,     // Reset pin, active low
    input  wire logic                    emu_halted,     // Core stopped for emulation
    input  wire logic                    sw_reset_req,   // Software reset instruction pulse
    input  wire logic                    vec_valid,      // Reset vector word present
    input  wire logic [31:0]             vec_data,       // Reset vector word
    input  wire logic [31:0]             ext_irq,        // External interrupt pulses
    input  wire logic                    nmi_req,        // Nonmaskable request
    input  wire logic                    flush_done,     // Cache flush finished
    output crc_pkg::crc_core_out_type    core_out,       // Sequencing and gating
    output logic                         host_irq_out,   // Host interrupt level
    output logic                         cache_enable,   // Program cache on
    output logic                         cache_freeze,   // Cache frozen
    output logic                         cache_flush,    // Flush in progress
    input  wire logic [6:0]              s_axi_awaddr,   // Write address
    input  wire logic                    s_axi_awvalid,  // Write address valid
    output logic                         s_axi_awready,  // Write address ready
    input  wire logic [31:0]             s_axi_wdata,    // Write data
    input  wire logic [3:0]              s_axi_wstrb,    // Write byte strobes
    input  wire logic                    s_axi_wvalid,   // Write data valid
    output logic                         s_axi_wready,   // Write data ready
    output logic [1:0]                   s_axi_bresp,    // Write response
    output logic                         s_axi_bvalid,   // Write response valid
    input  wire logic                    s_axi_bready,   // Write response ready
    input  wire logic [6:0]              s_axi_araddr,   // Read address
    input  wire logic                    s_axi_arvalid,  // Read address valid
    output logic                         s_axi_arready,  // Read address ready
    output logic [31:0]                  s_axi_rdata,    // Read data
    output logic [1:0]                   s_axi_rresp,    // Read response
    output logic                         s_axi_rvalid,   // Read data valid
    input  wire logic                    s_axi_rready    // Read data ready
);
    import crc_pkg::*;

    // Whole state in one register
    crc_state_reg_type state_reg;
    crc_state_reg_type state_next;

    // Unmapped or misaligned: error response
    function automatic logic idx_valid(input logic [6:0] addr);
        idx_valid = (addr[6:2] <= CRC_IDX_STAT) && (addr[1:0] == 2'h0);
    endfunction : idx_valid

    // Pointers are 23 bits, all else 16
    function automatic logic [22:0] width_mask(input logic [4:0] idx);
        width_mask = (idx >= CRC_IDX_AUXP0) ? 23'h7fffff : 23'h00ffff;
    endfunction : width_mask

    function automatic logic [22:0] merge(input logic [22:0] old_val,
                                          input logic [31:0] wdata,
                                          input logic [3:0]  wstrb);
        logic [31:0] val;
        val = {9'h000, old_val};
        for (int b = 0; b < 4; b++) begin
            if (wstrb[b]) begin
                val[b*8 +: 8] = wdata[b*8 +: 8];
            end
        end
        // Bits above 22 are dropped
        merge = val[22:0];
    endfunction : merge

    // Software reset touches only the first three status and the flag registers
    function automatic logic [CRC_NUM_REGS-1:0][22:0] load_reset(
        input logic [CRC_NUM_REGS-1:0][22:0] r,
        input logic                          hw);
        logic [CRC_NUM_REGS-1:0][22:0] o;
        // Unlisted registers keep their value
        o = r;
        o[CRC_IDX_ST0]  = CRC_RST_ST0;
        o[CRC_IDX_ST1]  = CRC_RST_ST1;
        o[CRC_IDX_ST2]  = CRC_RST_ST2;
        o[CRC_IDX_FLG0] = CRC_RST_ZERO;
        o[CRC_IDX_FLG1] = CRC_RST_ZERO;

        // Hardware-only part
        if (hw) begin
            o[CRC_IDX_ST3]  = CRC_RST_ST3;
            // Enables cleared too
            o[CRC_IDX_IEN0] = CRC_RST_ZERO;
            o[CRC_IDX_IEN1] = CRC_RST_ZERO;
            for (int i = CRC_IDX_TMP0; i < CRC_NUM_REGS; i++) begin
                o[i] = CRC_RST_ZERO;
            end

            if (CRC_RST_ST1[CRC_BIT_LEGACY]) begin
                o[CRC_IDX_TMP2] = CRC_RST_ZERO;
            end
        end
        load_reset = o;
    endfunction : load_reset

    // Decode and gating helpers
    logic        hw_req;
    logic        wr_go;
    logic        rd_go;
    logic [4:0]  wr_idx;
    logic [4:0]  rd_idx;
    logic [31:0] irq_flags;
    logic [31:0] irq_enables;
    logic        gate_open;

    // halt masks pin
    // A pin still low when halt ends is acted on
    assign hw_req = !hw_reset_b && !emu_halted;

    // Address and data taken only together
    assign wr_go  = s_axi_awvalid && s_axi_wvalid && !state_reg.bvalid;
    // One read in flight at a time
    assign rd_go  = s_axi_arvalid && !state_reg.rvalid;
    assign wr_idx = s_axi_awaddr[6:2];
    assign rd_idx = s_axi_araddr[6:2];

    assign irq_flags   = {state_reg.regs[CRC_IDX_FLG1][15:0],
                          state_reg.regs[CRC_IDX_FLG0][15:0]};
    assign irq_enables = {state_reg.regs[CRC_IDX_IEN1][15:0],
                          state_reg.regs[CRC_IDX_IEN0][15:0]};

    assign gate_open   = &state_reg.sp_set;

    always_comb begin
        logic [31:0] flags;
        logic [22:0] cur;
        flags      = 32'h0;
        cur        = 23'h0;
        state_next = state_reg;

        // Register bus writes
        // Response drops at the bready edge
        if (state_reg.bvalid && s_axi_bready) begin
            state_next.bvalid = 1'b0;
        end
        if (wr_go) begin
            state_next.bvalid = 1'b1;
            state_next.bresp  = CRC_RESP_OKAY;
            if (!idx_valid(s_axi_awaddr) || wr_idx == CRC_IDX_STAT) begin
                state_next.bresp = CRC_RESP_SLVERR;
            end else if (wr_idx == CRC_IDX_FLG0 || wr_idx == CRC_IDX_FLG1) begin
                // Flags are write-one-to-clear
                cur = merge(23'h0, s_axi_wdata, s_axi_wstrb);
                state_next.regs[wr_idx] = state_reg.regs[wr_idx] & ~cur;
            end else begin
                cur = merge(state_reg.regs[wr_idx], s_axi_wdata, s_axi_wstrb);
                state_next.regs[wr_idx] = cur & width_mask(wr_idx);
                // stack writes tracked
                // One pointer alone keeps the gate shut
                if (wr_idx == CRC_IDX_DSTK) begin
                    state_next.sp_set[0] = 1'b1;
                end
                if (wr_idx == CRC_IDX_SSTK) begin
                    state_next.sp_set[1] = 1'b1;
                end
            end
        end

        // Register bus reads
        // Read data stands until rready
        if (state_reg.rvalid && s_axi_rready) begin
            state_next.rvalid = 1'b0;
        end
        if (rd_go) begin
            state_next.rvalid = 1'b1;
            state_next.rresp  = CRC_RESP_OKAY;
            state_next.rdata  = 32'h0;
            if (!idx_valid(s_axi_araddr)) begin
                state_next.rresp = CRC_RESP_SLVERR;
            end else if (rd_idx == CRC_IDX_STAT) begin
                // Sequencer state for software
                state_next.rdata = {24'h0, state_reg.stack_cfg, state_reg.sp_set,
                                    1'b0, 3'(state_reg.state)};
            end else begin
                state_next.rdata = {9'h000, state_reg.regs[rd_idx]};
            end
        end

        // Flush completion; a software start in the same cycle wins
        if (flush_done && !(wr_go && wr_idx == CRC_IDX_ST3 && s_axi_wstrb[1]
                            && s_axi_wdata[CRC_BIT_FLUSH])) begin
            state_next.regs[CRC_IDX_ST3][CRC_BIT_FLUSH] = 1'b0;
        end

        if (state_reg.blank != 2'h0) begin
            state_next.blank = state_reg.blank - 2'h1;
        end else if (state_reg.state == CRC_RUN) begin
            // Set applied after clear, so a new event is never lost
            // Events outside RUN are dropped
            flags = {state_next.regs[CRC_IDX_FLG1][15:0],
                     state_next.regs[CRC_IDX_FLG0][15:0]} | ext_irq;
            state_next.regs[CRC_IDX_FLG0] = {7'h00, flags[15:0]};
            state_next.regs[CRC_IDX_FLG1] = {7'h00, flags[31:16]};
        end

        case (state_reg.state)
            CRC_RUN: begin
                // Instruction honoured only here
                // instruction entry
                if (sw_reset_req) begin
                    state_next.state = CRC_LOAD;
                    state_next.is_hw = 1'b0;
                end
            end

            CRC_HOLD: begin
                // Values stand while the pin is low
                // abort and load
                state_next.regs   = load_reset(state_reg.regs, 1'b1);
                state_next.sp_set = 2'h0;
                if (!hw_req) begin
                    state_next.state = CRC_LOAD;
                    state_next.blank = CRC_IRQ_BLANK;
                end
            end

            CRC_LOAD: begin
                // Undoes writes accepted in the reload cycle itself
                // shared reset values
                state_next.regs  = load_reset(state_next.regs, state_reg.is_hw);
                state_next.state = CRC_VEC;
            end

            CRC_VEC: begin
                // No timeout; waits for the source
                if (vec_valid) begin
                    state_next.stack_cfg = vec_data[29:28];
                    state_next.state     = CRC_ENTER;
                end
            end

            CRC_ENTER: begin
                state_next.state = CRC_RUN;
            end

            default: begin
                // Illegal codes restart the sequence
                state_next.state = CRC_HOLD;
            end
        endcase

        // Pin reset overrides everything, including a software sequence
        // Reloaded every cycle, so writes cannot stick
        if (hw_req) begin
            state_next.state  = CRC_HOLD;
            state_next.is_hw  = 1'b1;
            state_next.regs   = load_reset(state_reg.regs, 1'b1);
            state_next.sp_set = 2'h0;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            // Only status words 0, 1 and 3, the HOLD state and is_hw reset nonzero
            // The pin decides the rest once released
            state_reg           <= '0;
            state_reg.state     <= CRC_HOLD;
            state_reg.is_hw     <= 1'b1;
            state_reg.regs[CRC_IDX_ST0] <= CRC_RST_ST0;
            state_reg.regs[CRC_IDX_ST1] <= CRC_RST_ST1;
            state_reg.regs[CRC_IDX_ST2] <= CRC_RST_ST2;
            state_reg.regs[CRC_IDX_ST3] <= CRC_RST_ST3;
        end else begin
            state_reg <= state_next;
        end
    end

    always_comb begin
        core_out            = '0;
        // Covers the hold and the reload cycle
        core_out.abort      = (state_reg.state == CRC_HOLD) || (state_reg.state == CRC_LOAD);
        core_out.pipe_flush = core_out.abort;
        core_out.reg_load   = (state_reg.state == CRC_LOAD);
        core_out.vec_fetch_req = (state_reg.state == CRC_VEC);
        core_out.isr_start  = (state_reg.state == CRC_ENTER);
        core_out.stack_cfg  = state_reg.stack_cfg;
        core_out.int_gate_open = gate_open;

        core_out.maskable_int_take = gate_open && (state_reg.state == CRC_RUN)
                                     && !state_reg.regs[CRC_IDX_ST1][CRC_BIT_GMASK]
                                     && |(irq_flags & irq_enables);
        core_out.nmi_take = gate_open && (state_reg.state == CRC_RUN) && nmi_req;
    end

    // Host and cache lines mirror status register 3
    assign host_irq_out  = state_reg.regs[CRC_IDX_ST3][CRC_BIT_HOSTIRQ];
    assign cache_enable  = state_reg.regs[CRC_IDX_ST3][CRC_BIT_CACHEON];
    assign cache_freeze  = state_reg.regs[CRC_IDX_ST3][CRC_BIT_FREEZE];
    assign cache_flush   = state_reg.regs[CRC_IDX_ST3][CRC_BIT_FLUSH];

    // Ready is combinational on valid
    assign s_axi_awready = wr_go;
    assign s_axi_wready  = wr_go;
    assign s_axi_bvalid  = state_reg.bvalid;
    assign s_axi_bresp   = state_reg.bresp;
    // Read address ready whenever idle
    assign s_axi_arready = !state_reg.rvalid;
    assign s_axi_rvalid  = state_reg.rvalid;
    assign s_axi_rdata   = state_reg.rdata;
    assign s_axi_rresp   = state_reg.rresp;

endmodule : cpu_reset_control

/* crc_pkg.sv */
package crc_pkg;

    // Register indices; byte address is index times four
    localparam logic [4:0] CRC_IDX_ST0    = 5'h00;
    localparam logic [4:0] CRC_IDX_ST1    = 5'h01;
    localparam logic [4:0] CRC_IDX_ST2    = 5'h02;
    localparam logic [4:0] CRC_IDX_ST3    = 5'h03;
    localparam logic [4:0] CRC_IDX_IEN0   = 5'h04;
    localparam logic [4:0] CRC_IDX_IEN1   = 5'h05;
    localparam logic [4:0] CRC_IDX_FLG0   = 5'h06;
    localparam logic [4:0] CRC_IDX_FLG1   = 5'h07;
    localparam logic [4:0] CRC_IDX_TMP0   = 5'h08;
    localparam logic [4:0] CRC_IDX_TMP2   = 5'h0a;
    localparam logic [4:0] CRC_IDX_TRANS0 = 5'h0c;
    localparam logic [4:0] CRC_IDX_AUXP0  = 5'h0e;
    localparam logic [4:0] CRC_IDX_DSTK   = 5'h18;
    localparam logic [4:0] CRC_IDX_SSTK   = 5'h19;
    localparam logic [4:0] CRC_IDX_STAT   = 5'h1a;
    localparam int         CRC_NUM_REGS   = 26;

    // Field positions
    localparam int CRC_BIT_SHIFT_LO = 0;
    localparam int CRC_BIT_SHIFT_HI = 4;
    localparam int CRC_BIT_LEGACY   = 5;
    localparam int CRC_BIT_GMASK    = 11;
    localparam int CRC_BIT_HOSTIRQ  = 12;
    localparam int CRC_BIT_FLUSH    = 13;
    localparam int CRC_BIT_CACHEON  = 14;
    localparam int CRC_BIT_FREEZE   = 15;

    // Values after reset
    localparam logic [22:0] CRC_RST_ST0  = 23'h003800;
    localparam logic [22:0] CRC_RST_ST1  = 23'h002920;
    localparam logic [22:0] CRC_RST_ST2  = 23'h000000;
    localparam logic [22:0] CRC_RST_ST3  = 23'h001000;
    localparam logic [22:0] CRC_RST_ZERO = 23'h000000;

    // Cycles after leaving reset in which external events are not recognised
    localparam logic [1:0] CRC_IRQ_BLANK = 2'h3;

    localparam logic [1:0] CRC_RESP_OKAY   = 2'h0;
    localparam logic [1:0] CRC_RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        CRC_RUN,
        CRC_HOLD,
        CRC_LOAD,
        CRC_VEC,
        CRC_ENTER
    } crc_state_type;

    typedef struct packed {
        crc_state_type                         state;
        logic                                  is_hw;
        logic [CRC_NUM_REGS-1:0][22:0]         regs;
        logic [1:0]                            sp_set;
        logic [1:0]                            blank;
        logic [1:0]                            stack_cfg;
        logic                                  bvalid;
        logic [1:0]                            bresp;
        logic                                  rvalid;
        logic [31:0]                           rdata;
        logic [1:0]                            rresp;
    } crc_state_reg_type;

    typedef struct packed {
        logic        abort;
        logic        pipe_flush;
        logic        reg_load;
        logic        vec_fetch_req;
        logic        isr_start;
        logic [1:0]  stack_cfg;
        logic        int_gate_open;
        logic        maskable_int_take;
        logic        nmi_take;
    } crc_core_out_type;

endpackage : crc_pkg

/* crc_reset_source.sv */
module crc_reset_source #(
    parameter int MIN_HOLD = 8
) (
    input  wire logic        clock,       // Core clock
    input  wire logic        fetch_req,   // Vector wanted
    input  wire logic [1:0]  cfg,         // Stack choice offered
    output logic             hw_reset_b,  // Reset pin
    output logic             emu_halted,  // Emulation stop
    output logic             vec_valid,   // Vector present
    output logic [31:0]      vec_data     // Vector word
);
    timeunit 1ns;
    timeprecision 1ps;
    int          wait_n = 0;
    logic [31:0] v;
    initial begin
        hw_reset_b = 1'b1;
        emu_halted = 1'b0;
        vec_valid  = 1'b0;
        vec_data   = 32'h0;
    end
    task automatic pin_reset(input int n, input logic halt);
        emu_halted <= halt;
        hw_reset_b <= 1'b0;
        repeat ((n < MIN_HOLD) ? MIN_HOLD : n) @(posedge clock);
        hw_reset_b <= 1'b1;
        @(posedge clock);
        emu_halted <= 1'b0;
    endtask : pin_reset
    // Idle word keeps toggling so a stale vector is never mistaken for a fresh one
    always @(posedge clock) begin
        v = $urandom;
        v[29:28] = cfg;
        if (vec_valid) begin
            vec_valid <= 1'b0;
            vec_data  <= ~vec_data;
        end else if (fetch_req && wait_n == 0) begin
            vec_valid <= 1'b1;
            vec_data  <= v;
            wait_n    <= $urandom_range(3);
        end else begin
            vec_data <= ~vec_data;
            if (fetch_req) begin
                wait_n <= wait_n - 1;
            end
        end
    end
endmodule : crc_reset_source

/* cpu_reset_control_properties.sv */
module crc_properties
    import crc_pkg::*;
(
    input wire logic           clock,         // Core clock
    input wire logic           rst_b,         // Async reset
    input wire logic           hw_reset_b,    // Reset pin
    input wire logic           emu_halted,    // Emulation stop
    input wire logic           sw_reset_req,  // Software reset
    input wire logic           vec_valid,     // Vector present
    input wire logic [31:0]    vec_data,      // Vector word
    input crc_core_out_type    core_out,      // Sequencing
    input wire logic           host_irq_out,  // Host level
    input wire logic           cache_enable,  // Cache on
    input wire logic           cache_freeze,  // Cache frozen
    input wire logic           cache_flush    // Flush busy
);
    logic       run;
    logic       pin_ok;
    logic [1:0] vec_cfg;
    assign run = !core_out.abort && !core_out.vec_fetch_req && !core_out.isr_start;
    assign pin_ok = hw_reset_b || emu_halted;
    assign vec_cfg = vec_data[29:28];
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    sequence s_vec_taken;
        core_out.vec_fetch_req && vec_valid && pin_ok ##1 pin_ok;
    endsequence
    sequence s_sw;
        sw_reset_req && run && pin_ok ##1 pin_ok;
    endsequence
    property p_hold;
        !pin_ok |=> core_out.abort && core_out.pipe_flush;
    endproperty
    a_hold: assert property (p_hold) else $error("pin reset did not abort");
    property p_host_irq_out_bit;
        !pin_ok |=> host_irq_out;
    endproperty
    a_host_irq_out_bit: assert property (p_host_irq_out_bit) else $error("host level not high");
    property p_flush;
        !pin_ok |=> !cache_flush;
    endproperty
    a_flush: assert property (p_flush) else $error("flush not cleared");
    property p_cache_enable_bit;
        !pin_ok |=> !cache_enable;
    endproperty
    a_cache_enable_bit: assert property (p_cache_enable_bit) else $error("cache left on");
    property p_frz;
        !pin_ok |=> !cache_freeze;
    endproperty
    a_frz: assert property (p_frz) else $error("cache left frozen");
    property p_emu;
        emu_halted && run && !sw_reset_req |=> run;
    endproperty
    a_emu: assert property (p_emu) else $error("reset acted while halted");
    property p_gate;
        !pin_ok |=> !core_out.int_gate_open && !core_out.nmi_take;
    endproperty
    a_gate: assert property (p_gate) else $error("gate open after reset");
    property p_mask;
        core_out.maskable_int_take |-> core_out.int_gate_open && run;
    endproperty
    a_mask: assert property (p_mask) else $error("interrupt taken while gated");
    property p_cfg;
        core_out.vec_fetch_req && vec_valid && pin_ok |=> core_out.stack_cfg == $past(vec_cfg);
    endproperty
    a_cfg: assert property (p_cfg) else $error("stack choice wrong");
    property p_isr;
        s_vec_taken |-> core_out.isr_start ##1 run;
    endproperty
    a_isr: assert property (p_isr) else $error("routine not entered");
    property p_sw;
        s_sw |-> core_out.reg_load ##1 core_out.vec_fetch_req;
    endproperty
    a_sw: assert property (p_sw) else $error("software reset flow wrong");
endmodule : crc_properties
bind cpu_reset_control crc_properties u_props (.clock, .rst_b, .hw_reset_b, .emu_halted,
    .sw_reset_req, .vec_valid, .vec_data, .core_out, .host_irq_out, .cache_enable,
    .cache_freeze, .cache_flush);

/* cpu_reset_control_tb_top.sv */
module cpu_reset_control_tb_top;
    import crc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, rst_b, hw_reset_b, emu_halted, sw_reset_req, vec_valid, nmi_req, flush_done;
    logic [31:0] vec_data, ext_irq, s_axi_wdata, s_axi_rdata, d;
    logic host_irq_out, cache_enable, cache_freeze, cache_flush;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [6:0] s_axi_awaddr, s_axi_araddr;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, cfg;
    crc_core_out_type core_out;
    logic [22:0] mdl [CRC_NUM_REGS];
    int n_mismatch = 0;
    int checks_done = 0;
    int cyc = 0;
    cpu_reset_control dut (.clock, .rst_b, .hw_reset_b, .emu_halted, .sw_reset_req, .vec_valid,
        .vec_data, .ext_irq, .nmi_req, .flush_done, .core_out, .host_irq_out, .cache_enable,
        .cache_freeze, .cache_flush, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);
    crc_reset_source #(.MIN_HOLD(8)) src (.clock, .fetch_req(core_out.vec_fetch_req), .cfg,
        .hw_reset_b, .emu_halted, .vec_valid, .vec_data);
    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : results
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [6:0] a, input logic [31:0] wd, input logic [1:0] er);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= wd;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        do @(posedge clock); while (!(s_axi_awready && s_axi_wready));
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid  <= 1'b0;
        do @(posedge clock); while (!s_axi_bvalid);
        chk(s_axi_bresp, er);
    endtask : wr
    task automatic rd(input logic [6:0] a, input logic [31:0] ed, input logic [1:0] er);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge clock); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge clock); while (!s_axi_rvalid);
        chk(s_axi_rdata, ed);
        chk(s_axi_rresp, er);
    endtask : rd
    task automatic check_all;
        for (int i = 0; i < CRC_NUM_REGS; i++) begin
            rd(7'(i * 4), {9'h0, mdl[i]}, CRC_RESP_OKAY);
        end
    endtask : check_all
    task automatic sw_mdl;
        mdl[0] = 23'h003800;
        mdl[1] = 23'h002920;
        mdl[2] = 23'h0;
        mdl[6] = 23'h0;
        mdl[7] = 23'h0;
    endtask : sw_mdl
    task automatic hw_mdl;
        foreach (mdl[i]) mdl[i] = 23'h0;
        mdl[3] = 23'h001000;
        sw_mdl;
    endtask : hw_mdl
    task automatic fill;
        for (int i = 8; i < CRC_NUM_REGS; i++) begin
            d = $urandom & ((i < 14) ? 32'hffff : 32'h7fffff);
            wr(7'(i * 4), d, CRC_RESP_OKAY);
            mdl[i] = d[22:0];
        end
    endtask : fill
    task automatic wait_run;
        do @(posedge clock); while (core_out.abort || core_out.vec_fetch_req || core_out.isr_start);
        repeat (4) @(posedge clock);
    endtask : wait_run
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // Bounds a hang anywhere in the sequence
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            results;
        end
    end
    initial begin
        rst_b = 1'b0;
        {sw_reset_req, nmi_req, flush_done, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 6'h0;
        {ext_irq, s_axi_wdata, s_axi_awaddr, s_axi_araddr} = 78'h0;
        {s_axi_wstrb, s_axi_bready, s_axi_rready, cfg} = 8'hfe;
        void'($urandom(30913));
        repeat (16) @(posedge clock);
        rst_b <= 1'b1;
        hw_mdl;
        wait_run;
        chk(core_out.stack_cfg, cfg);
        check_all;
        chk({host_irq_out, cache_flush, cache_enable, cache_freeze}, 4'h8);
        $display("test power-on done");
        fill;
        check_all;
        wr(7'h0c, 32'hf000, CRC_RESP_OKAY);
        chk({host_irq_out, cache_flush, cache_enable, cache_freeze}, 4'hf);
        flush_done <= 1'b1;
        @(posedge clock);
        flush_done <= 1'b0;
        @(posedge clock);
        chk(cache_flush, 1'b0);
        cfg <= 2'h1;
        src.pin_reset(3, 1'b0);
        chk(core_out.int_gate_open, 1'b0);
        hw_mdl;
        wait_run;
        chk(core_out.stack_cfg, cfg);
        check_all;
        chk({host_irq_out, cache_flush, cache_enable, cache_freeze}, 4'h8);
        $display("test pin reset done");
        fill;
        src.pin_reset(4, 1'b1);
        repeat (2) @(posedge clock);
        check_all;
        $display("test halted reset done");
        d = $urandom;
        ext_irq <= d;
        @(posedge clock);
        ext_irq <= 32'h0;
        mdl[6] = {7'h0, d[15:0]};
        mdl[7] = {7'h0, d[31:16]};
        check_all;
        wr(7'h04, 32'h0, CRC_RESP_OKAY);
        cfg <= 2'h3;
        sw_reset_req <= 1'b1;
        @(posedge clock);
        sw_reset_req <= 1'b0;
        sw_mdl;
        wait_run;
        chk(core_out.stack_cfg, cfg);
        check_all;
        rd(7'h68, 32'hf0, CRC_RESP_OKAY);
        $display("test software reset done");
        src.pin_reset(8, 1'b0);
        hw_mdl;
        wait_run;
        nmi_req <= 1'b1;
        wr(7'h60, 32'h10, CRC_RESP_OKAY);
        chk(core_out.nmi_take, 1'b0);
        wr(7'h64, 32'h20, CRC_RESP_OKAY);
        chk(core_out.nmi_take, 1'b1);
        nmi_req <= 1'b0;
        wr(7'h10, 32'h1, CRC_RESP_OKAY);
        ext_irq <= 32'h1;
        @(posedge clock);
        ext_irq <= 32'h0;
        @(posedge clock);
        chk(core_out.maskable_int_take, 1'b0);
        wr(7'h04, 32'h2120, CRC_RESP_OKAY);
        chk(core_out.maskable_int_take, 1'b1);
        $display("test interrupt gate done");
        rd(7'h6c, 32'h0, CRC_RESP_SLVERR);
        rd(7'h21, 32'h0, CRC_RESP_SLVERR);
        wr(7'h68, 32'h0, CRC_RESP_SLVERR);
        $display("test refusals done");
        results;
    end
endmodule : cpu_reset_control_tb_top
